/* File: core/fh_nand_defines.vh */
// Constants for the NAND flash host controller: register map, fields, command codes and timing.
`ifndef FH_NAND_DEFINES_VH
`define FH_NAND_DEFINES_VH

// Register byte offsets on the APB side.
`define FH_REG_CTRL       8'h00
`define FH_REG_ADDR       8'h04
`define FH_REG_WDATA      8'h08
`define FH_REG_RDATA      8'h0c
`define FH_REG_STATUS     8'h10
`define FH_REG_CFG        8'h14

// Operation codes written to the low bits of the control register.
`define FH_OP_READ_A      4'h0
`define FH_OP_READ_B      4'h1
`define FH_OP_READ_SPARE  4'h2
`define FH_OP_IDENT       4'h3
`define FH_OP_RESET       4'h4
`define FH_OP_STATUS      4'h5
`define FH_OP_PROG_SETUP  4'h6
`define FH_OP_PROG_EXEC   4'h7
`define FH_OP_COPY_EXEC   4'h8
`define FH_OP_ERASE       4'h9
`define FH_OP_DATA_WR     4'ha
`define FH_OP_DATA_RD     4'hb

// Flash command codes.
`define FH_CMD_READ_A     8'h00
`define FH_CMD_READ_B     8'h01
`define FH_CMD_READ_SPARE 8'h50
`define FH_CMD_IDENT      8'h90
`define FH_CMD_RESET      8'hff
`define FH_CMD_STATUS     8'h70
`define FH_CMD_PROG       8'h80
`define FH_CMD_PROG_GO    8'h10
`define FH_CMD_COPY_GO    8'h8a
`define FH_CMD_ERASE      8'h60
`define FH_CMD_ERASE_GO   8'hd0

// Field positions of the decoded operation word.
`define FH_DEC_W          18
`define FH_DEC_CMD_HI     7
`define FH_DEC_HAS_CMD    8
`define FH_DEC_NADDR_LO   9
`define FH_DEC_NADDR_HI   10
`define FH_DEC_ROW_ONLY   11
`define FH_DEC_CMD2       12
`define FH_DEC_WAIT       13
`define FH_DEC_DWR        14
`define FH_DEC_DRD        15
`define FH_DEC_VALID      16
`define FH_DEC_BUSY_OK    17

// Status and configuration bit positions.
`define FH_ST_ACTIVE      0
`define FH_ST_READY       1
`define FH_ST_DONE        2
`define FH_ST_ERR         3
`define FH_CFG_X16        0
`define FH_CFG_SKIP_SPARE 1
`define FH_CFG_HOLD_CE    2
`define FH_CFG_RESET      3'h4

// Address field layout.
`define FH_ADDR_COL_HI    7
`define FH_ADDR_LO_HI     15
`define FH_ADDR_HI_HI     23
`define FH_SPARE_MASK_X8  8'h0f
`define FH_SPARE_MASK_X16 8'h07

// Timing, in nanoseconds, and cycle counts rounded up at the clock rate.
`define FH_CLK_PERIOD_NS  50
`define FH_T_SETUP_NS     20
`define FH_T_LOW_NS       25
`define FH_T_HIGH_NS      15
`define FH_T_WB_NS        100
`define FH_CYC(ns)        (((ns) + `FH_CLK_PERIOD_NS - 1) / `FH_CLK_PERIOD_NS)

`endif

/* File: core/fh_nand_host.v */
// Host controller that drives a NAND flash over its pins and takes orders over APB.
`timescale 1ns/1ps
`include "fh_nand_defines.vh"

module fh_nand_host (
    // Clock and reset.
    input  wire        ref_clk,
    input  wire        rst_n,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Flash pins.
    output reg         ce_n,
    output reg         cle,
    output reg         ale,
    output reg         we_n,
    output reg         read_strobe_n,
    output reg  [15:0] io_out,
    output reg         io_oe,
    input  wire [15:0] io_in,
    input  wire        rb_n,
    output reg         spare_skip
);

    // Bus cycle phase lengths in clock cycles, worked out at full width and then cut to the counter width.
    localparam integer T_SET_I  = `FH_CYC(`FH_T_SETUP_NS);
    localparam integer T_LOW_I  = `FH_CYC(`FH_T_LOW_NS);
    localparam integer T_HIGH_I = `FH_CYC(`FH_T_HIGH_NS);
    localparam integer T_WB_I   = `FH_CYC(`FH_T_WB_NS);
    localparam [3:0]   T_SET    = T_SET_I[3:0];
    localparam [3:0]   T_LOW    = T_LOW_I[3:0];
    localparam [3:0]   T_HIGH   = T_HIGH_I[3:0];
    localparam [3:0]   T_WB     = T_WB_I[3:0];
    localparam [3:0]   T_TOT    = T_SET + T_LOW + T_HIGH;

    // Engine states, one-hot.
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_READY = 5'h02;
    localparam [4:0] ST_CYC   = 5'h04;
    localparam [4:0] ST_WB    = 5'h08;
    localparam [4:0] ST_BUSY  = 5'h10;

    // Kinds of flash bus cycle.
    localparam [1:0] K_CMD1 = 2'h0;
    localparam [1:0] K_ADDR = 2'h1;
    localparam [1:0] K_CMD2 = 2'h2;
    localparam [1:0] K_DATA = 2'h3;

    // Decodes an operation into its command code, address cycles and phases.
    function [`FH_DEC_W-1:0] fh_dec;
        input [3:0] op;
        input       x16;
        begin
            fh_dec = {`FH_DEC_W{1'b0}};
            // Fields from the top: busy-safe, valid, read, write, wait, second command, row only, count, has command.
            case (op)
                `FH_OP_READ_A:     fh_dec = {2'b01, 4'b0010, 3'b011, 1'b1, `FH_CMD_READ_A};
                `FH_OP_READ_B:     fh_dec = {1'b0, ~x16, 4'b0010, 3'b011, 1'b1, `FH_CMD_READ_B};
                `FH_OP_READ_SPARE: fh_dec = {2'b01, 4'b0010, 3'b011, 1'b1, `FH_CMD_READ_SPARE};
                `FH_OP_IDENT:      fh_dec = {2'b01, 4'b0000, 3'b001, 1'b1, `FH_CMD_IDENT};
                `FH_OP_RESET:      fh_dec = {2'b11, 4'b0010, 3'b000, 1'b1, `FH_CMD_RESET};
                `FH_OP_STATUS:     fh_dec = {2'b11, 4'b0000, 3'b000, 1'b1, `FH_CMD_STATUS};
                `FH_OP_PROG_SETUP: fh_dec = {2'b01, 4'b0000, 3'b011, 1'b1, `FH_CMD_PROG};
                `FH_OP_PROG_EXEC:  fh_dec = {2'b01, 4'b0010, 3'b000, 1'b1, `FH_CMD_PROG_GO};
                `FH_OP_COPY_EXEC:  fh_dec = {2'b01, 4'b0010, 3'b011, 1'b1, `FH_CMD_COPY_GO};
                `FH_OP_ERASE:      fh_dec = {2'b01, 4'b0011, 3'b110, 1'b1, `FH_CMD_ERASE};
                `FH_OP_DATA_WR:    fh_dec = {2'b11, 4'b0100, 3'b000, 1'b0, 8'h00};
                `FH_OP_DATA_RD:    fh_dec = {2'b11, 4'b1000, 3'b000, 1'b0, 8'h00};
                default:           fh_dec = {`FH_DEC_W{1'b0}};
            endcase
        end
    endfunction

    // Picks the byte for one address cycle; for spare reads the upper bits of the column byte are forced low.
    function [7:0] fh_addr_byte;
        input [1:0]  idx;
        input [23:0] addr;
        input [3:0]  op;
        input        x16;
        begin
            fh_addr_byte = 8'h00;
            if (op == `FH_OP_IDENT) begin
                fh_addr_byte = 8'h00;
            end else if (idx == 2'h0) begin
                fh_addr_byte = addr[`FH_ADDR_COL_HI:0];
                if (op == `FH_OP_READ_SPARE) begin
                    fh_addr_byte = fh_addr_byte & (x16 ? `FH_SPARE_MASK_X16 : `FH_SPARE_MASK_X8);
                end
            end else if (idx == 2'h1) begin
                fh_addr_byte = addr[`FH_ADDR_LO_HI:`FH_ADDR_COL_HI+1];
            end else begin
                fh_addr_byte = addr[`FH_ADDR_HI_HI:`FH_ADDR_LO_HI+1];
            end
        end
    endfunction

    // Software-visible registers.
    reg [3:0]  op_q;
    reg [23:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [2:0]  cfg_q;
    reg        done_q;
    reg        err_q;

    // Engine state.
    reg [4:0]            st_q;
    reg [1:0]            kind_q;
    reg [1:0]            aidx_q;
    reg [1:0]            aleft_q;
    reg [3:0]            cnt_q;
    reg [`FH_DEC_W-1:0]  dec_q;

    // Bus decode.
    wire                 bus_wr   = psel & penable & pready & pwrite;
    wire                 ctrl_wr  = bus_wr & (paddr == `FH_REG_CTRL);
    wire [`FH_DEC_W-1:0] dec_new  = fh_dec(pwdata[3:0], cfg_q[`FH_CFG_X16]);
    wire                 idle     = (st_q == ST_IDLE);
    wire                 accept   = ctrl_wr & idle & dec_new[`FH_DEC_VALID];
    wire                 refuse   = ctrl_wr & ~accept;
    wire [1:0]           naddr    = dec_q[`FH_DEC_NADDR_HI:`FH_DEC_NADDR_LO];
    wire                 cyc_end  = (st_q == ST_CYC) & (cnt_q == T_TOT - 4'h1);
    wire                 cap_edge = (st_q == ST_CYC) & (cnt_q == T_SET + T_LOW - 4'h1);
    wire                 is_read  = (kind_q == K_DATA) & dec_q[`FH_DEC_DRD];
    wire                 finish   = cyc_end & ((kind_q == K_CMD2) | (kind_q == K_DATA) |
                                   (kind_q == K_CMD1 & naddr == 2'h0 & ~dec_q[`FH_DEC_CMD2]) |
                                   (kind_q == K_ADDR & aleft_q == 2'h1 & ~dec_q[`FH_DEC_CMD2]));
    wire [3:0]           cnt_nx   = (st_q == ST_CYC && !cyc_end) ? cnt_q + 4'h1 : 4'h0;
    wire                 strobe   = (cnt_nx >= T_SET) & (cnt_nx < T_SET + T_LOW);

    // Kind and address index of the coming bus cycle, so the pins show its setup phase on time.
    reg [1:0] kind_nx;
    reg [1:0] aidx_nx;
    always @* begin
        kind_nx = kind_q;
        aidx_nx = aidx_q;
        if (cyc_end && !finish) begin
            if (kind_q == K_CMD1 && naddr != 2'h0) begin
                kind_nx = K_ADDR;
            end else if (kind_q == K_ADDR && aleft_q != 2'h1) begin
                aidx_nx = aidx_q + 2'h1;
            end else begin
                kind_nx = K_CMD2;
            end
        end
    end

    // Pins follow the engine while a bus cycle is under way or about to begin.
    wire pins_on = (st_q == ST_CYC && !finish) | (st_q == ST_READY && rb_n) |
                   (accept & (dec_new[`FH_DEC_BUSY_OK] | rb_n));

    // Read mux for the APB side.
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `FH_REG_CTRL:   rd_mux = {28'h0000000, op_q};
            `FH_REG_ADDR:   rd_mux = {8'h00, addr_q};
            `FH_REG_WDATA:  rd_mux = {16'h0000, wdata_q};
            `FH_REG_RDATA:  rd_mux = {16'h0000, rdata_q};
            `FH_REG_STATUS: rd_mux = {28'h0000000, err_q, done_q, rb_n, ~idle};
            `FH_REG_CFG:    rd_mux = {29'h00000000, cfg_q};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // APB slave: one setup cycle then a single access cycle with pready high.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            prdata  <= (psel & ~penable) ? rd_mux : prdata;
            pslverr <= psel & ~penable & (paddr > `FH_REG_CFG | paddr[1:0] != 2'b00);
        end
    end

    // Register writes and sticky flags; a hardware set wins over a software clear.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            op_q    <= 4'h0;
            addr_q  <= 24'h000000;
            wdata_q <= 16'h0000;
            cfg_q   <= `FH_CFG_RESET;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            if (accept) begin
                op_q <= pwdata[3:0];
            end
            if (bus_wr && paddr == `FH_REG_ADDR) begin
                addr_q <= pwdata[23:0];
            end
            if (bus_wr && paddr == `FH_REG_WDATA) begin
                wdata_q <= pwdata[15:0];
            end
            if (bus_wr && paddr == `FH_REG_CFG) begin
                cfg_q <= pwdata[2:0];
            end
            if ((finish && !dec_q[`FH_DEC_WAIT]) || (st_q == ST_BUSY && rb_n)) begin
                done_q <= 1'b1;
            end else if (bus_wr && paddr == `FH_REG_STATUS && pwdata[`FH_ST_DONE]) begin
                done_q <= 1'b0;
            end
            if (refuse) begin
                err_q <= 1'b1;
            end else if (bus_wr && paddr == `FH_REG_STATUS && pwdata[`FH_ST_ERR]) begin
                err_q <= 1'b0;
            end
        end
    end

    // Operation sequencer: command, address cycles, second command, busy wait.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q    <= ST_IDLE;
            kind_q  <= K_CMD1;
            aidx_q  <= 2'h0;
            aleft_q <= 2'h0;
            cnt_q   <= 4'h0;
            dec_q   <= {`FH_DEC_W{1'b0}};
            rdata_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_nx;
            if (cap_edge && is_read) begin
                rdata_q <= cfg_q[`FH_CFG_X16] ? io_in : {8'h00, io_in[7:0]};
            end
            case (st_q)
                ST_IDLE: begin
                    if (accept) begin
                        dec_q   <= dec_new;
                        aleft_q <= dec_new[`FH_DEC_NADDR_HI:`FH_DEC_NADDR_LO];
                        aidx_q  <= dec_new[`FH_DEC_ROW_ONLY] ? 2'h1 : 2'h0;
                        kind_q  <= dec_new[`FH_DEC_HAS_CMD] ? K_CMD1 : K_DATA;
                        st_q    <= (dec_new[`FH_DEC_BUSY_OK] | rb_n) ? ST_CYC : ST_READY;
                    end
                end
                ST_READY: begin
                    if (rb_n) begin
                        st_q <= ST_CYC;
                    end
                end
                ST_CYC: begin
                    kind_q <= kind_nx;
                    aidx_q <= aidx_nx;
                    if (finish) begin
                        st_q <= dec_q[`FH_DEC_WAIT] ? ST_WB : ST_IDLE;
                    end else if (cyc_end && kind_q == K_ADDR && aleft_q != 2'h1) begin
                        aleft_q <= aleft_q - 2'h1;
                    end
                end
                ST_WB: begin
                    if (cnt_q == T_WB - 4'h1) begin
                        st_q <= ST_BUSY;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_BUSY: begin
                    if (rb_n) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Flash pin drivers, all registered; strobes, latch enables and data from the next phase of the bus cycle, spare_skip from the config.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ce_n          <= 1'b1;
            cle           <= 1'b0;
            ale           <= 1'b0;
            we_n          <= 1'b1;
            read_strobe_n <= 1'b1;
            io_out        <= 16'h0000;
            io_oe         <= 1'b0;
            spare_skip    <= 1'b0;
        end else begin
            spare_skip    <= cfg_q[`FH_CFG_SKIP_SPARE];
            ce_n          <= ~(cfg_q[`FH_CFG_HOLD_CE] | ~idle | accept);
            if (pins_on) begin
                cle           <= (st_q == ST_CYC) ? (kind_nx != K_ADDR && kind_nx != K_DATA) :
                                 (accept ? dec_new[`FH_DEC_HAS_CMD] : dec_q[`FH_DEC_HAS_CMD]);
                ale           <= (st_q == ST_CYC) & (kind_nx == K_ADDR);
                we_n          <= ~(strobe & ~is_read);
                read_strobe_n <= ~(strobe & is_read);
                io_oe         <= ~is_read | (st_q != ST_CYC);
                if (st_q != ST_CYC) begin
                    io_out <= {8'h00, accept ? dec_new[`FH_DEC_CMD_HI:0] : dec_q[`FH_DEC_CMD_HI:0]};
                end else if (kind_nx == K_ADDR) begin
                    io_out <= {8'h00, fh_addr_byte(aidx_nx, addr_q, op_q, cfg_q[`FH_CFG_X16])};
                end else if (kind_nx == K_CMD2) begin
                    io_out <= {8'h00, dec_q[`FH_DEC_CMD2] ? `FH_CMD_ERASE_GO : 8'h00};
                end else if (kind_nx == K_DATA) begin
                    io_out <= cfg_q[`FH_CFG_X16] ? wdata_q : {8'h00, wdata_q[7:0]};
                end else begin
                    io_out <= {8'h00, dec_q[`FH_DEC_CMD_HI:0]};
                end
            end else begin
                cle           <= 1'b0;
                ale           <= 1'b0;
                we_n          <= 1'b1;
                read_strobe_n <= 1'b1;
                io_oe         <= 1'b0;
            end
        end
    end

endmodule // fh_nand_host

/* File: testbench/fh_nand_host_checker.sv */
// Port-level assertions for the NAND flash host controller.
`timescale 1ns/1ps

module fh_nand_host_checker (
    // Clock, reset and APB.
    input wire logic        ref_clk, rst_n, psel, penable, pready, pslverr,
    input wire logic [7:0]  paddr,
    // Flash pins.
    input wire logic        ce_n, cle, ale, we_n, read_strobe_n, io_oe, rb_n,
    input wire logic [15:0] io_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // An APB setup cycle and a one-cycle write strobe pulse.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_we_pulse;
        !we_n ##1 we_n;
    endsequence

    // The slave answers in the cycle after setup, for one cycle only.
    chk_apb_ready: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pready && pslverr)
        else $error("unmapped access not flagged");
    // Strobes and latch enables on the flash side.
    chk_strobe_sel: assert property (!we_n |-> !ce_n)
        else $error("write strobe without select");
    chk_latch_excl: assert property (!(cle && ale))
        else $error("both latch enables high");
    chk_cmd_upper: assert property ((cle || ale) && !we_n |-> io_out[15:8] == 8'h00 && io_oe)
        else $error("command or address on upper lines");
    chk_cmd_set: assert property (cle && !we_n |-> io_out[7:0] inside {8'h00, 8'h01, 8'h50, 8'h90, 8'hff,
        8'h70, 8'h80, 8'h10, 8'h8a, 8'h60, 8'hd0})
        else $error("undefined command code");
    chk_we_hold: assert property (s_we_pulse |-> $stable(io_out) && $stable(cle) && $stable(ale))
        else $error("value moved under write strobe");
    chk_we_width: assert property ($fell(we_n) |=> $rose(we_n))
        else $error("write strobe not one cycle");
    chk_busy_sel: assert property (!rb_n |-> !ce_n)
        else $error("select released while busy");
    chk_busy_cmd: assert property (!rb_n && cle && !we_n |-> io_out[7:0] inside {8'hff, 8'h70})
        else $error("command issued while busy");
    chk_read_release: assert property (!read_strobe_n |-> !io_oe && !ce_n)
        else $error("host drives lines during read");
endmodule // fh_nand_host_checker

bind fh_nand_host fh_nand_host_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .io_oe(io_oe), .rb_n(rb_n), .io_out(io_out));

/* File: testbench/fh_nand_flash_model.sv */
// Behavioural model of the NAND flash that the controller drives.
`timescale 1ns/1ps

module fh_nand_flash_model #(
    parameter int BUSY_CYC = 20
) (
    // Flash pins seen from the device.
    input wire logic        ref_clk, ce_n, cle, ale, we_n, read_strobe_n,
    input wire logic [15:0] io,
    output logic     [15:0] dq_out,
    output logic            rb_low
);
    logic [9:0] log_q[$];
    logic [9:0] col = 10'h000;  // Column pointer over 528 page register columns.
    logic [7:0] cmd = 8'h00;
    int         acnt = 3;
    int         busy = 0;

    function automatic logic [7:0] pat(input logic [9:0] c);
        return c[7:0] ^ (8'h5a + {c[9:8], 6'h00});
    endfunction

    // Open-drain busy output pulled low while an operation runs.
    assign rb_low = (busy != 0);
    // Counted down by non-blocking assignment so the controller never races the busy line at its clock edge.
    always @(posedge ref_clk) begin
        if (busy > 0) busy <= busy - 1;
    end

    // Commands, addresses and data are taken on the strobe rising edge.
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            if (busy == 0 || io[7:0] == 8'hff || io[7:0] == 8'h70) begin
                log_q.push_back({2'd0, io[7:0]});
                cmd = io[7:0];
                acnt = 0;
                if (cmd == 8'h10 || cmd == 8'hd0) busy = BUSY_CYC;
            end
        end else if (!ce_n && ale && acnt < 3) begin
            log_q.push_back({2'd1, io[7:0]});
            if (acnt == 0) col = (cmd == 8'h50) ? {6'h20, io[3:0]} : {1'b0, cmd == 8'h01, io[7:0]};
            if (acnt == 2 && (cmd inside {8'h00, 8'h01, 8'h50, 8'h8a})) busy = BUSY_CYC;
            acnt++;
        end else if (!ce_n && !cle && !ale) begin
            log_q.push_back({2'd2, io[7:0]});
        end
    end

    // Each read strobe fall drives the next word; released lines show the inverse.
    always @(negedge read_strobe_n) begin
        if (!ce_n) begin
            dq_out = {~pat(col), pat(col)};
            col = col + 10'h001;
        end
    end
    always @(posedge read_strobe_n) dq_out = ~dq_out;
    initial dq_out = 16'h0000;
endmodule // fh_nand_flash_model

/* File: testbench/fh_nand_host_tb_top.sv */
// Self-checking bench for the NAND flash host controller.
`timescale 1ns/1ps
`include "fh_nand_defines.vh"

module fh_nand_host_tb_top;
    logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, io_oe, spare_skip, rb_low;
    logic [15:0] io_out, dq_out;
    int          n_mismatch = 0;
    int          check_count = 0;
    wire  [15:0] io_in = io_oe ? io_out : dq_out;
    wire         rb_n = rb_low ? 1'b0 : 1'b1;  // Pull-up on the busy line.

    always #25 ref_clk = ~ref_clk;

    fh_nand_host uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
        .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
        .io_in(io_in), .rb_n(rb_n), .spare_skip(spare_skip));
    fh_nand_flash_model mdl (.ref_clk(ref_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .io(io_in), .dq_out(dq_out), .rb_low(rb_low));

    function automatic logic [7:0] pat(input logic [9:0] c);
        return c[7:0] ^ (8'h5a + {c[9:8], 6'h00});
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Compares a register or pin value.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Compares the next bus cycle the flash latched: kind 0 command, 1 address, 2 data.
    task automatic check_log(input logic [9:0] exp);
        logic [9:0] got;
        got = (mdl.log_q.size() != 0) ? mdl.log_q.pop_front() : 10'h3ff;
        check({22'h0, got}, {22'h0, exp}, "flash cycle");
    endtask

    // One APB transfer; waits for ready under a bound.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) check(0, 1, "apb hang");
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Starts an operation, polls for done or error, then clears both.
    task automatic run_op(input logic [3:0] op, output logic [31:0] st);
        int n;
        wr(`FH_REG_CTRL, {28'h0, op});
        n = 0;
        do begin rd(`FH_REG_STATUS, st); n++; end while (st[3:2] == 2'b00 && n < 300);
        wr(`FH_REG_STATUS, 32'hc);
    endtask

    task automatic addr3(input logic [23:0] a);
        check_log({2'd1, a[7:0]});
        check_log({2'd1, a[15:8]});
        check_log({2'd1, a[23:16]});
    endtask

    // Main sequence: registers, every read kind, identifier, program, copy-back, erase and refusals.
    initial begin
        logic [31:0] r, a, d;
        logic [9:0]  col;
        logic        e;
        r = $urandom(32'hdc219ce8);
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`FH_REG_CFG, r);
        check(r, 32'h4, "cfg reset");
        apb(1'b1, 8'h18, 32'h1, r, e);
        check({31'h0, e}, 32'h1, "unmapped error");
        d = $urandom & 32'h2;
        wr(`FH_REG_CFG, d);
        rd(`FH_REG_CFG, r);
        check(r, d, "cfg value");
        check({31'h0, spare_skip}, {31'h0, d[1]}, "spare pin");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 32'hffffff : ($urandom & 32'hffffff);
            wr(`FH_REG_ADDR, a);
            run_op(4'(i % 3), r);
            check({30'h0, r[3:2]}, 32'h1, "read done");
            check_log({2'd0, (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h01 : 8'h50});
            addr3((i % 3 == 2) ? a[23:0] & 24'hffff0f : a[23:0]);
            col = (i % 3 == 2) ? {6'h20, a[3:0]} : {1'b0, i % 3 == 1, a[7:0]};
            for (int k = 0; k < 2; k++) begin
                run_op(`FH_OP_DATA_RD, r);
                rd(`FH_REG_RDATA, r);
                check({24'h0, r[7:0]}, {24'h0, pat(col + 10'(k))}, "read word");
            end
        end
        run_op(`FH_OP_IDENT, r);
        check_log({2'd0, 8'h90});
        check_log({2'd1, 8'h00});
        run_op(`FH_OP_RESET, r);
        check_log({2'd0, 8'hff});
        run_op(`FH_OP_STATUS, r);
        check_log({2'd0, 8'h70});
        a = $urandom & 32'hffffff;
        wr(`FH_REG_ADDR, a);
        run_op(`FH_OP_PROG_SETUP, r);
        check_log({2'd0, 8'h80});
        addr3(a[23:0]);
        repeat (2) begin
            d = $urandom & 32'hffff;
            wr(`FH_REG_WDATA, d);
            run_op(`FH_OP_DATA_WR, r);
            check_log({2'd2, d[7:0]});
        end
        run_op(`FH_OP_PROG_EXEC, r);
        check_log({2'd0, 8'h10});
        run_op(`FH_OP_READ_A, r);
        run_op(`FH_OP_COPY_EXEC, r);
        check_log({2'd0, 8'h00});
        addr3(a[23:0]);
        check_log({2'd0, 8'h8a});
        addr3(a[23:0]);
        run_op(`FH_OP_ERASE, r);
        check({30'h0, r[3:2]}, 32'h1, "erase done");
        check_log({2'd0, 8'h60});
        check_log({2'd1, a[15:8]});
        check_log({2'd1, a[23:16]});
        check_log({2'd0, 8'hd0});
        wr(`FH_REG_CFG, 32'h1);
        run_op(`FH_OP_READ_B, r);
        check({30'h0, r[3:2]}, 32'h2, "x16 second half refused");
        run_op(4'hc, r);
        check({30'h0, r[3:2]}, 32'h2, "invalid op refused");
        check(mdl.log_q.size(), 0, "stray flash cycles");
        stop_test();
    end

    // Watchdog at 60000 cycles: the whole run needs about a thousand cycles.
    initial begin
        #(50 * 60000);
        n_mismatch++;
        stop_test();
    end
endmodule // fh_nand_host_tb_top
